// file: src/trc_command_port.sv
// I2C target command layer: link-side byte engine and core-side register store
`timescale 1ns/1ps
// Overview of operation
// - The device acknowledges every address, command and data byte that it accepts as receiver.
// - After the configuration command one written data byte becomes the new configuration value.
// - After the clock command a start index follows and data fills seconds through year in order.
// - The seconds byte carries the oscillator stop control, so seconds zero with it clear runs the clock.
// - The hours byte holds the hour value, the 12/24-hour selection and the AM/PM indicator.
// - Minutes and year are stored as binary-coded decimal bytes exactly as written.
// - The day-of-week register holds the whole weekday code byte.
// - Date and month take numeric values in which one is the first day and January.
// - After the high-threshold command two bytes are written, whole degrees first.
// - After the read-temperature command and a read address the temperature MSB is returned first.
// - A controller NACK after the first temperature byte ends the read cleanly.
// - Any access through the clock command clears the clock alarm flag unless a new alarm sets it in the same cycle.
module trc_command_port (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic linkClk,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic [15:0] tempWord,
	input wire logic alarmEvent,
	output logic [7:0] configValue,
	output logic [7:0] clockSeconds,
	output logic [7:0] clockMinutes,
	output logic [7:0] clockHours,
	output logic [7:0] clockDay,
	output logic [7:0] clockDate,
	output logic [7:0] clockMonth,
	output logic [7:0] clockYear,
	output logic oscRun,
	output logic hour12Mode,
	output logic pmIndicator,
	output logic [15:0] high_temp_threshold,
	output logic clock_alarm_flag
);
	function automatic logic [3:0] nextPtr(input logic [3:0] p);
		nextPtr = (p == trc_pkg::IDX_YEAR) ? trc_pkg::IDX_SECONDS : 4'(p + 4'h1);
	endfunction

	// Link domain
	logic [1:0] sclSync_q, sdaSync_q, ceSync_q;
	logic sclPrev_q, sdaPrev_q;
	trc_pkg::trc_state_e state_q;
	logic [3:0] bitCnt_q, ptr_q, wrIdx_q;
	logic [7:0] shift_q, txShift_q, wrData_q;
	logic devAck_q, hostAck_q, oe_q;
	logic wrTog_q, rdTog_q, clrTog_q;
	// Core domain
	logic [2:0] wrSync_q, rdSync_q, clrSync_q;
	logic [7:0] clockReg_q [0:trc_pkg::CLOCK_REG_COUNT-1];
	logic [7:0] config_q, rdData_q;
	logic [15:0] thresh_q;
	logic alarmFlag_q;

	wire sclNow = sclSync_q[1];
	wire sdaNow = sdaSync_q[1];
	wire linkCe = ceSync_q[1];
	wire sclRise = ~sclPrev_q & sclNow;
	wire sclFall = sclPrev_q & ~sclNow;
	// START/STOP: data moves while the bus clock stays high
	wire startCond = sclNow & sclPrev_q & sdaPrev_q & ~sdaNow;
	wire stopCond = sclNow & sclPrev_q & ~sdaPrev_q & sdaNow;
	wire inAck = devAck_q | hostAck_q;
	wire byteDone = bitCnt_q == trc_pkg::BIT_LAST;
	wire isTx = state_q == trc_pkg::ST_RDATA;
	wire isRx = (state_q == trc_pkg::ST_ADDR) | (state_q == trc_pkg::ST_CMD)
		| (state_q == trc_pkg::ST_PTR) | (state_q == trc_pkg::ST_WDATA);

	wire isAddrW = shift_q == trc_pkg::ADDR_WRITE;
	wire isAddrR = shift_q == trc_pkg::ADDR_READ;
	wire isCmdCfg = shift_q == trc_pkg::CMD_CONFIG;
	wire isCmdClock = shift_q == trc_pkg::CMD_CLOCK;
	wire isCmdThresh = shift_q == trc_pkg::CMD_HIGH_THRESH;
	wire isCmdTemp = shift_q == trc_pkg::CMD_READ_TEMP;
	wire cmdOk = isCmdCfg | isCmdClock | isCmdThresh | isCmdTemp;
	wire ptrOk = shift_q < trc_pkg::CLOCK_REGS;
	wire wrOk = (ptr_q <= trc_pkg::IDX_YEAR) | (ptr_q == trc_pkg::IDX_CONFIG)
		| (ptr_q == trc_pkg::IDX_THRESH_MSB) | (ptr_q == trc_pkg::IDX_THRESH_LSB);
	wire rxAccept = (state_q == trc_pkg::ST_ADDR) ? (isAddrW | isAddrR) :
		(state_q == trc_pkg::ST_CMD) ? cmdOk :
		(state_q == trc_pkg::ST_PTR) ? ptrOk :
		(state_q == trc_pkg::ST_WDATA) ? wrOk : 1'b0;
	wire [3:0] cmdPtr = isCmdCfg ? trc_pkg::IDX_CONFIG :
		isCmdThresh ? trc_pkg::IDX_THRESH_MSB :
		isCmdTemp ? trc_pkg::IDX_TEMP_MSB : ptr_q;
	wire trc_pkg::trc_state_e rxNext = ~rxAccept ? trc_pkg::ST_IGNORE :
		(state_q == trc_pkg::ST_ADDR) ? (isAddrR ? trc_pkg::ST_RDATA : trc_pkg::ST_CMD) :
		(state_q == trc_pkg::ST_CMD) ? (isCmdClock ? trc_pkg::ST_PTR : trc_pkg::ST_WDATA) :
		trc_pkg::ST_WDATA;
	wire rxByteFall = sclFall & byteDone & ~inAck & isRx;
	wire txByteFall = sclFall & byteDone & ~inAck & isTx;

	always_ff @(posedge linkClk or posedge reset) begin
		if (reset) begin
			ceSync_q <= 2'b00;
		end else begin
			ceSync_q <= {ceSync_q[0], ce};
		end
	end

	always_ff @(posedge linkClk or posedge reset) begin
		if (reset) begin
			sclSync_q <= 2'b11;
			sdaSync_q <= 2'b11;
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else if (linkCe) begin
			sclSync_q <= {sclSync_q[0], sclIn};
			sdaSync_q <= {sdaSync_q[0], sdaIn};
			sclPrev_q <= sclNow;
			sdaPrev_q <= sdaNow;
		end
	end

	always_ff @(posedge linkClk or posedge reset) begin
		if (reset) begin
			state_q <= trc_pkg::ST_IDLE;
			bitCnt_q <= 4'h0;
			shift_q <= 8'h00;
			txShift_q <= 8'h00;
			devAck_q <= 1'b0;
			hostAck_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (linkCe) begin
			if (stopCond) begin
				state_q <= trc_pkg::ST_IDLE;
				devAck_q <= 1'b0;
				hostAck_q <= 1'b0;
				oe_q <= 1'b0;
			end else if (startCond) begin
				// Plain and repeated START both restart address reception
				state_q <= trc_pkg::ST_ADDR;
				bitCnt_q <= 4'h0;
				devAck_q <= 1'b0;
				hostAck_q <= 1'b0;
				oe_q <= 1'b0;
			end else if (sclRise) begin
				if (hostAck_q && sdaNow) begin
					state_q <= trc_pkg::ST_IGNORE;
				end else if (!inAck && (isRx || isTx)) begin
					bitCnt_q <= 4'(bitCnt_q + 4'h1);
					shift_q <= {shift_q[6:0], sdaNow};
				end
			end else if (sclFall) begin
				if (inAck) begin
					devAck_q <= 1'b0;
					hostAck_q <= 1'b0;
					bitCnt_q <= 4'h0;
					oe_q <= isTx & ~rdData_q[7];
					txShift_q <= rdData_q;
				end else if (rxByteFall) begin
					// Refused bytes get no acknowledge and park the engine
					devAck_q <= rxAccept;
					oe_q <= rxAccept;
					state_q <= rxNext;
				end else if (txByteFall) begin
					hostAck_q <= 1'b1;
					oe_q <= 1'b0;
				end else if (isTx) begin
					oe_q <= ~txShift_q[6];
					txShift_q <= {txShift_q[6:0], 1'b0};
				end
			end
		end
	end

	// Pointer and crossing events; data words stay put until the next toggle
	always_ff @(posedge linkClk or posedge reset) begin
		if (reset) begin
			ptr_q <= trc_pkg::PTR_RST;
			wrIdx_q <= trc_pkg::PTR_RST;
			wrData_q <= 8'h00;
			wrTog_q <= 1'b0;
			rdTog_q <= 1'b0;
			clrTog_q <= 1'b0;
		end else if (linkCe) begin
			if (rxByteFall && rxAccept && state_q == trc_pkg::ST_CMD) begin
				ptr_q <= cmdPtr;
				rdTog_q <= ~rdTog_q;
				clrTog_q <= clrTog_q ^ isCmdClock;
			end else if (rxByteFall && rxAccept && state_q == trc_pkg::ST_PTR) begin
				ptr_q <= shift_q[3:0];
				rdTog_q <= ~rdTog_q;
			end else if (rxByteFall && rxAccept && state_q == trc_pkg::ST_WDATA) begin
				wrIdx_q <= ptr_q;
				wrData_q <= shift_q;
				wrTog_q <= ~wrTog_q;
				ptr_q <= nextPtr(ptr_q);
				rdTog_q <= ~rdTog_q;
			end else if (txByteFall) begin
				// Advancing here leaves the whole acknowledge bit for the fetch
				ptr_q <= nextPtr(ptr_q);
				rdTog_q <= ~rdTog_q;
			end
		end
	end

	assign sdaOut = 1'b0;
	assign sdaOe = oe_q;

	wire wrEvent = wrSync_q[2] ^ wrSync_q[1];
	wire rdEvent = rdSync_q[2] ^ rdSync_q[1];
	wire clrEvent = clrSync_q[2] ^ clrSync_q[1];
	wire [7:0] statusByte = {7'h00, alarmFlag_q};
	wire [7:0] readMux = (ptr_q <= trc_pkg::IDX_YEAR) ? clockReg_q[ptr_q[2:0]] :
		(ptr_q == trc_pkg::IDX_CONFIG) ? config_q :
		(ptr_q == trc_pkg::IDX_STATUS) ? statusByte :
		(ptr_q == trc_pkg::IDX_THRESH_MSB) ? thresh_q[15:8] :
		(ptr_q == trc_pkg::IDX_THRESH_LSB) ? thresh_q[7:0] :
		(ptr_q == trc_pkg::IDX_TEMP_MSB) ? tempWord[15:8] :
		(ptr_q == trc_pkg::IDX_TEMP_LSB) ? tempWord[7:0] : 8'h00;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wrSync_q <= 3'b000;
			rdSync_q <= 3'b000;
			clrSync_q <= 3'b000;
			alarmFlag_q <= 1'b0;
			rdData_q <= trc_pkg::READ_RST;
		end else if (ce) begin
			wrSync_q <= {wrSync_q[1:0], wrTog_q};
			rdSync_q <= {rdSync_q[1:0], rdTog_q};
			clrSync_q <= {clrSync_q[1:0], clrTog_q};
			// A new alarm beats a clear arriving in the same cycle
			if (alarmEvent) begin
				alarmFlag_q <= 1'b1;
			end else if (clrEvent) begin
				alarmFlag_q <= 1'b0;
			end
			if (rdEvent) begin
				rdData_q <= readMux;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			config_q <= trc_pkg::CONFIG_RST;
			thresh_q <= trc_pkg::THRESH_RST;
			clockReg_q[0] <= trc_pkg::SECONDS_RST;
			for (int i = 1; i < trc_pkg::CLOCK_REG_COUNT; i++) begin
				clockReg_q[i] <= trc_pkg::CLOCK_RST;
			end
		end else if (ce && wrEvent) begin
			// Clock bytes are stored whole: BCD, hour mode and stop bit kept as written
			if (wrIdx_q <= trc_pkg::IDX_YEAR) begin
				clockReg_q[wrIdx_q[2:0]] <= wrData_q;
			end else if (wrIdx_q == trc_pkg::IDX_CONFIG) begin
				config_q <= wrData_q;
			end else if (wrIdx_q == trc_pkg::IDX_THRESH_MSB) begin
				thresh_q[15:8] <= wrData_q;
			end else if (wrIdx_q == trc_pkg::IDX_THRESH_LSB) begin
				thresh_q[7:0] <= wrData_q;
			end
		end
	end

	assign configValue = config_q;
	assign clockSeconds = clockReg_q[trc_pkg::IDX_SECONDS[2:0]];
	assign clockMinutes = clockReg_q[trc_pkg::IDX_MINUTES[2:0]];
	assign clockHours = clockReg_q[trc_pkg::IDX_HOURS[2:0]];
	assign clockDay = clockReg_q[trc_pkg::IDX_DAY[2:0]];
	assign clockDate = clockReg_q[trc_pkg::IDX_DATE[2:0]];
	assign clockMonth = clockReg_q[trc_pkg::IDX_MONTH[2:0]];
	assign clockYear = clockReg_q[trc_pkg::IDX_YEAR[2:0]];
	assign oscRun = ~clockSeconds[trc_pkg::SEC_STOP_BIT];
	assign hour12Mode = clockHours[trc_pkg::HOUR_12H_BIT];
	assign pmIndicator = clockHours[trc_pkg::HOUR_12H_BIT] & clockHours[trc_pkg::HOUR_PM_BIT];
	assign high_temp_threshold = thresh_q;
	assign clock_alarm_flag = alarmFlag_q;
endmodule

// file: src/trc_pkg.sv
// Constants, indices and state encoding of the thermometer/clock command port
package trc_pkg;
	localparam logic [7:0] ADDR_WRITE = 8'h9E;
	localparam logic [7:0] ADDR_READ = 8'h9F;
	localparam logic [7:0] CMD_CONFIG = 8'hAC;
	localparam logic [7:0] CMD_CLOCK = 8'hC0;
	localparam logic [7:0] CMD_HIGH_THRESH = 8'hA1;
	localparam logic [7:0] CMD_READ_TEMP = 8'hAA;
	// Internal register index space shared by both clock domains
	localparam logic [3:0] IDX_SECONDS = 4'h0;
	localparam logic [3:0] IDX_MINUTES = 4'h1;
	localparam logic [3:0] IDX_HOURS = 4'h2;
	localparam logic [3:0] IDX_DAY = 4'h3;
	localparam logic [3:0] IDX_DATE = 4'h4;
	localparam logic [3:0] IDX_MONTH = 4'h5;
	localparam logic [3:0] IDX_YEAR = 4'h6;
	localparam logic [3:0] IDX_CONFIG = 4'h8;
	localparam logic [3:0] IDX_STATUS = 4'h9;
	localparam logic [3:0] IDX_THRESH_MSB = 4'hA;
	localparam logic [3:0] IDX_THRESH_LSB = 4'hB;
	localparam logic [3:0] IDX_TEMP_MSB = 4'hC;
	localparam logic [3:0] IDX_TEMP_LSB = 4'hD;
	localparam logic [7:0] CLOCK_REGS = 8'h07;
	localparam int CLOCK_REG_COUNT = 7;
	// Field positions inside the seconds and hours bytes
	localparam int SEC_STOP_BIT = 7;
	localparam int HOUR_12H_BIT = 6;
	localparam int HOUR_PM_BIT = 5;
	// Values after reset, and the bit count that ends a byte
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [7:0] SECONDS_RST = 8'h80;
	localparam logic [7:0] CLOCK_RST = 8'h00;
	localparam logic [15:0] THRESH_RST = 16'h0000;
	localparam logic [7:0] READ_RST = 8'h00;
	localparam logic [3:0] PTR_RST = 4'h0;
	localparam logic [3:0] BIT_LAST = 4'h8;
	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_ADDR = 7'b0000010,
		ST_CMD = 7'b0000100,
		ST_PTR = 7'b0001000,
		ST_WDATA = 7'b0010000,
		ST_RDATA = 7'b0100000,
		ST_IGNORE = 7'b1000000
	} trc_state_e;
endpackage

// file: tb/tb.sv
// Self-checking bench for the thermometer and clock command port
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0, reset = 1'b1, linkClk = 1'b0, alarmEvent = 1'b0, ack, ce = 1'b1;
	logic [15:0] tempWord = 16'h0000;
	logic scl, sdaDrv, sdaOut, sdaOe, oscRun, hour12Mode, pmIndicator, clock_alarm_flag;
	logic [7:0] configValue, sec, mins, hours, day, date, month, year, rb;
	logic [15:0] high_temp_threshold;
	int n_mismatch = 0, check_count = 0;
	wire sdaBus = sdaDrv & !sdaOe;
	logic [8:0] rows [10] = '{{8'hAC, 1'b1}, {8'hC0, 1'b1}, {8'hA1, 1'b1}, {8'hAA, 1'b1},
		{8'hEE, 1'b0}, {8'h22, 1'b0}, {8'hAD, 1'b0}, {8'hA2, 1'b0}, {8'h17, 1'b0}, {8'hC7, 1'b0}};
	logic [7:0] cw [8] = '{8'h00, 8'h00, 8'h30, 8'h51, 8'h05, 8'h01, 8'h01, 8'h98};
	always #5 clk = ~clk;
	initial begin
		#3.1;
		forever #7.5 linkClk = ~linkClk;
	end
	trc_i2c_host trc_i2c_host_i (.clk(clk), .sdaBus(sdaBus), .scl(scl), .sdaDrv(sdaDrv));
	trc_command_port trc_command_port_i (.clk(clk), .reset(reset), .ce(ce), .linkClk(linkClk),
		.sclIn(scl), .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe(sdaOe), .tempWord(tempWord),
		.alarmEvent(alarmEvent), .configValue(configValue), .clockSeconds(sec),
		.clockMinutes(mins), .clockHours(hours), .clockDay(day), .clockDate(date),
		.clockMonth(month), .clockYear(year), .oscRun(oscRun), .hour12Mode(hour12Mode),
		.pmIndicator(pmIndicator), .high_temp_threshold(high_temp_threshold),
		.clock_alarm_flag(clock_alarm_flag));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic w(input logic [7:0] d, input logic e);
		trc_i2c_host_i.wr(d, ack);
		chk(ack, e);
	endtask
	task automatic r(input logic last, input logic [7:0] e);
		trc_i2c_host_i.rd(last, rb);
		chk(rb, e);
	endtask
	task automatic hdr(input logic [7:0] c);
		trc_i2c_host_i.start();
		w(trc_pkg::ADDR_WRITE, 1'b1);
		w(c, 1'b1);
	endtask
	task automatic rdhdr();
		trc_i2c_host_i.start();
		w(trc_pkg::ADDR_READ, 1'b1);
	endtask
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge clk);
		reset = 1'b0;
		repeat (10) @(negedge clk);
		foreach (rows[k]) begin
			trc_i2c_host_i.start();
			w(trc_pkg::ADDR_WRITE, 1'b1);
			w(rows[k][8:1], rows[k][0]);
			if (!rows[k][0]) w(8'h55, 1'b0);
			trc_i2c_host_i.stop();
		end
		// Configuration, clock and threshold chained by repeated START
		hdr(trc_pkg::CMD_CONFIG);
		w(8'h11, 1'b1);
		hdr(trc_pkg::CMD_CLOCK);
		foreach (cw[k]) w(cw[k], 1'b1);
		hdr(trc_pkg::CMD_HIGH_THRESH);
		w(8'h32, 1'b1);
		w(8'h00, 1'b1);
		w(8'h77, 1'b0);
		trc_i2c_host_i.stop();
		trc_i2c_host_i.settle();
		chk(configValue, 16'h0011);
		chk({sec, mins}, 16'h0030);
		chk({hours, day}, 16'h5105);
		chk({date, month}, 16'h0101);
		chk(year, 16'h0098);
		chk({oscRun, hour12Mode, pmIndicator}, 16'h0006);
		chk(high_temp_threshold, 16'h3200);
		alarmEvent = 1'b1;
		@(negedge clk);
		alarmEvent = 1'b0;
		chk(clock_alarm_flag, 16'h0001);
		hdr(trc_pkg::CMD_CLOCK);
		w(8'h01, 1'b1);
		rdhdr();
		r(1'b0, 8'h30);
		r(1'b1, 8'h51);
		trc_i2c_host_i.stop();
		chk(clock_alarm_flag, 16'h0000);
		hdr(trc_pkg::CMD_CLOCK);
		w(8'h07, 1'b0);
		trc_i2c_host_i.start();
		w(8'h9C, 1'b0);
		tempWord = 16'h1980;
		hdr(trc_pkg::CMD_READ_TEMP);
		rdhdr();
		r(1'b1, 8'h19);
		hdr(trc_pkg::CMD_READ_TEMP);
		rdhdr();
		r(1'b0, 8'h19);
		r(1'b1, 8'h80);
		alarmEvent = 1'b1;
		@(negedge clk);
		alarmEvent = 1'b0;
		hdr(trc_pkg::CMD_CONFIG);
		rdhdr();
		r(1'b0, 8'h11);
		r(1'b1, 8'h01);
		trc_i2c_host_i.stop();
		// A port frozen by its clock enable must neither answer nor lose state
		ce = 1'b0;
		trc_i2c_host_i.start();
		w(trc_pkg::ADDR_WRITE, 1'b0);
		trc_i2c_host_i.stop();
		ce = 1'b1;
		chk({configValue, 7'h00, clock_alarm_flag}, 16'h1101);
		reset = 1'b1;
		repeat (3) @(negedge clk);
		chk({configValue, sec}, 16'h0080);
		chk(oscRun, 16'h0000);
		chk(high_temp_threshold, 16'h0000);
		chk(clock_alarm_flag, 16'h0000);
		reset = 1'b0;
		// The port must take a whole command again soon after a mid-run reset
		repeat (4) @(negedge clk);
		hdr(trc_pkg::CMD_CONFIG);
		rdhdr();
		r(1'b1, 8'h00);
		trc_i2c_host_i.stop();
		wrap_up();
	end
endmodule

// file: tb/trc_i2c_host.sv
// Behavioural I2C bus controller facing the command port
`timescale 1ns/1ps
module trc_i2c_host (
	input wire logic clk,
	input wire logic sdaBus,
	output logic scl,
	output logic sdaDrv
);
	initial begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end
	// 25 core cycles per quarter bit keeps each phase far above the crossing delay
	task automatic q();
		repeat (25) @(negedge clk);
	endtask
	task automatic start();
		sdaDrv = 1'b1;
		q();
		scl = 1'b1;
		q();
		sdaDrv = 1'b0;
		q();
		scl = 1'b0;
		q();
	endtask
	task automatic stop();
		sdaDrv = 1'b0;
		q();
		scl = 1'b1;
		q();
		sdaDrv = 1'b1;
		q();
	endtask
	// The port keeps no write busy time, so a short quiet bus gap stands in for the settle wait
	task automatic settle();
		repeat (8) q();
	endtask
	// Data moves only a quarter bit after the clock falls, so no false START is seen
	task automatic bitx(input logic b, output logic r);
		sdaDrv = b;
		q();
		scl = 1'b1;
		q();
		r = sdaBus;
		q();
		scl = 1'b0;
		q();
	endtask
	task automatic wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask
	task automatic rd(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(last, r);
	endtask
endmodule

// file: tb/trc_properties.sv
// Concurrent checks on the pins of the command port
`timescale 1ns/1ps
module trc_properties (
	input wire logic clk,
	input wire logic reset,
	input wire logic linkClk,
	input wire logic sclIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic alarmEvent,
	input wire logic [7:0] configValue,
	input wire logic [7:0] clockSeconds,
	input wire logic [7:0] clockHours,
	input wire logic oscRun,
	input wire logic hour12Mode,
	input wire logic pmIndicator,
	input wire logic [15:0] high_temp_threshold,
	input wire logic clock_alarm_flag
);
	a_open_drain:
		assert property (@(posedge linkClk) disable iff (reset) sdaOe |-> !sdaOut)
		else $error("data pin driven high");
	// The device may only move the data line while the bus clock is low
	a_oe_scl_low:
		assert property (@(posedge linkClk) disable iff (reset) $changed(sdaOe) |-> !sclIn)
		else $error("data drive changed with bus clock high");
	a_osc_run:
		assert property (@(posedge clk) disable iff (reset) oscRun == !clockSeconds[7])
		else $error("run control does not follow seconds byte");
	a_hour_mode:
		assert property (@(posedge clk) disable iff (reset) hour12Mode == clockHours[6])
		else $error("hour format does not follow hours byte");
	a_pm_flag:
		assert property (@(posedge clk) disable iff (reset)
			pmIndicator == (clockHours[6] & clockHours[5])) else $error("wrong afternoon flag");
	a_flag_set:
		assert property (@(posedge clk) disable iff (reset) alarmEvent |=> clock_alarm_flag)
		else $error("alarm flag not set");
	a_flag_rise:
		assert property (@(posedge clk) disable iff (reset)
			$rose(clock_alarm_flag) |-> $past(alarmEvent)) else $error("alarm flag set alone");
	a_flag_clear:
		assert property (@(posedge clk) disable iff (reset)
			$fell(clock_alarm_flag) |-> !$past(alarmEvent)) else $error("clear beat alarm");
	// Looked at on the first edge after release, when the store has settled to its reset values
	a_reset_vals:
		assert property (@(posedge clk) $fell(reset) |-> configValue == 8'h00
			&& clockSeconds == 8'h80
			&& high_temp_threshold == 16'h0000 && !clock_alarm_flag) else $error("reset values");
	c_ack: cover property (@(posedge linkClk) $rose(sdaOe));
	c_clear: cover property (@(posedge clk) $fell(clock_alarm_flag));
	c_thresh: cover property (@(posedge clk) $changed(high_temp_threshold));
endmodule
bind trc_command_port trc_properties trc_properties_i (.clk(clk), .reset(reset),
	.linkClk(linkClk), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .alarmEvent(alarmEvent),
	.configValue(configValue), .clockSeconds(clockSeconds), .clockHours(clockHours),
	.oscRun(oscRun), .hour12Mode(hour12Mode), .pmIndicator(pmIndicator),
	.high_temp_threshold(high_temp_threshold), .clock_alarm_flag(clock_alarm_flag));
